/* hdl/lpcn_pkg.sv */
`default_nettype none
package lpcn_pkg;
	// clock and probe timing
	localparam int CLK_KHZ           = 20000;
	localparam int PROBE_UNIT_MS     = 50;
	localparam int PROBE_UNIT_CYCLES = PROBE_UNIT_MS * CLK_KHZ;
	localparam logic [11:0] PROBE_STEP_MS = 12'h032;

	// rate code points
	localparam logic [11:0] BASE_STEP_KBPS = 12'h040;
	localparam logic [11:0] SUB_STEP_KBPS  = 12'h008;
	localparam logic [11:0] ASYM768_KBPS   = 12'h300;
	localparam logic [11:0] ASYM1536_KBPS  = 12'h600;
	localparam logic [11:0] ASYM2048_KBPS  = 12'h800;
	localparam logic [11:0] ASYM2304_KBPS  = 12'h900;
	localparam logic [5:0]  BASE_N_MIN     = 6'h03;
	localparam logic [5:0]  BASE_N_MAX     = 6'h24;
	localparam logic [2:0]  SUB_I_ZERO     = 3'h0;
	localparam logic [2:0]  SUB_I_ONE      = 3'h1;

	// margin octet layout
	localparam int         MARGIN_EN_BIT    = 0;
	localparam int         MARGIN_LSB       = 1;
	localparam int         MARGIN_MSB       = 5;
	localparam logic [6:0] MARGIN_OFFSET_DB = 7'h0a;

	// line levels
	localparam logic signed [1:0] LVL_POS = 2'sh1;
	localparam logic signed [1:0] LVL_NEG = 2'sh3;

	// register byte addresses
	localparam logic [3:0] ADR_CTRL = 4'h0;
	localparam logic [3:0] ADR_CFG  = 4'h4;
	localparam logic [3:0] ADR_STAT = 4'h8;
	localparam logic [3:0] ADR_RATE = 4'hc;

	typedef enum logic [2:0] {PSD_SYM, PSD_ASYM768, PSD_ASYM1536, PSD_ASYM2048,
		PSD_ASYM2304} lpcn_psd_t;

	typedef enum logic [2:0] {ST_IDLE, ST_HS1, ST_PROBE, ST_HS2, ST_ACTIVE} lpcn_state_t;

	// one capability or mode-select message
	typedef struct packed {
		logic       probe_mode;
		logic       four_wire;
		logic       regen;
		logic       diag;
		lpcn_psd_t  psd;
		logic [5:0] base_n;
		logic [2:0] sub_i;
		logic [3:0] power_backoff_field;
		logic [5:0] dur;
		logic [2:0] scr;
		logic [7:0] wc_oct;
		logic [7:0] cc_oct;
	} lpcn_msg_t;

	typedef struct packed {
		logic [8:0] pad;
		logic [5:0] probe_n;
		logic [2:0] sub_i;
		logic [5:0] base_n;
		lpcn_psd_t  psd;
		logic       regen;
		logic       diag;
		logic       four_wire;
		logic       probe_en;
		logic       go;
	} lpcn_ctrl_t;

	typedef struct packed {
		logic [2:0] pad;
		logic [7:0] cc_oct;
		logic [7:0] wc_oct;
		logic [2:0] scr;
		logic [5:0] dur;
		logic [3:0] power_backoff_field;
	} lpcn_cfg_t;

	typedef struct packed {
		logic [9:0]  pad;
		logic [5:0]  best_n;
		logic [2:0]  agreed_sub;
		logic [5:0]  agreed_n;
		logic        peer_diag;
		logic        peer_regen;
		logic        peer_four_wire;
		logic        peer_probe;
		lpcn_state_t phase;
	} lpcn_stat_t;

	typedef struct packed {
		logic [18:0] pad;
		logic        ok;
		logic [11:0] kbps;
	} lpcn_rate_t;

	// total payload rate of a code point
	function automatic logic [11:0] rate_kbps(lpcn_psd_t psd, logic [5:0] n, logic [2:0] i);
		logic [11:0] sub;
		sub = (i == SUB_I_ONE) ? SUB_STEP_KBPS : 12'h000;
		case (psd)
			PSD_SYM:      rate_kbps = {6'h00, n} * BASE_STEP_KBPS + {9'h000, i} * SUB_STEP_KBPS;
			PSD_ASYM768:  rate_kbps = ASYM768_KBPS + sub;
			PSD_ASYM1536: rate_kbps = ASYM1536_KBPS + sub;
			PSD_ASYM2048: rate_kbps = ASYM2048_KBPS;
			PSD_ASYM2304: rate_kbps = ASYM2304_KBPS;
			default:      rate_kbps = 12'h000;
		endcase
	endfunction

	// legal combination of base and sub fields
	function automatic logic rate_ok(lpcn_psd_t psd, logic [5:0] n, logic [2:0] i);
		case (psd)
			PSD_SYM:      rate_ok = n >= BASE_N_MIN && n <= BASE_N_MAX &&
				!(n == BASE_N_MAX && i > SUB_I_ONE);
			PSD_ASYM768,
			PSD_ASYM1536: rate_ok = (i == SUB_I_ZERO) || (i == SUB_I_ONE);
			PSD_ASYM2048,
			PSD_ASYM2304: rate_ok = 1'b1;
			default:      rate_ok = 1'b0;
		endcase
	endfunction

	// signed margin in whole dB, -10 to +21
	function automatic logic signed [6:0] margin_db(logic [7:0] oct);
		margin_db = $signed({2'b00, oct[MARGIN_MSB:MARGIN_LSB]}) - $signed(MARGIN_OFFSET_DB);
	endfunction

	// snr less required snr against target margin; a disabled margin always passes
	function automatic logic qualifies(logic signed [7:0] snr, logic signed [7:0] req,
		logic [7:0] oct);
		logic signed [8:0] d;
		logic signed [8:0] m;
		d = $signed({snr[7], snr}) - $signed({req[7], req});
		m = 9'(margin_db(oct));
		qualifies = !oct[MARGIN_EN_BIT] || (d >= m);
	endfunction

	// probe segment length in ms
	function automatic logic [11:0] dur_ms(logic [5:0] dur);
		dur_ms = {6'h00, dur} * PROBE_STEP_MS;
	endfunction

	// bit to level, same in probe and activation
	function automatic logic signed [1:0] map_level(logic b);
		map_level = b ? LVL_POS : LVL_NEG;
	endfunction

	// the single spectral shaper for every mode
	function automatic logic signed [2:0] shape(logic signed [1:0] cur, logic signed [1:0] prev);
		shape = 3'(cur) + 3'(prev);
	endfunction

	// byte-lane merge for register writes
	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] sel);
		for (int b = 0; b < 4; b++) begin
			merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		end
	endfunction
endpackage
`default_nettype wire

/* hdl/lpcn_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface lpcn_if
	import lpcn_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i
);
	logic      dev_valid;
	lpcn_msg_t dev_msg;
	logic      peer_valid;
	lpcn_msg_t peer_msg;
	logic      probe_on;

	modport dev (input clk_i, rst_i, peer_valid, peer_msg,
		output dev_valid, dev_msg, probe_on);
	modport peer (input clk_i, rst_i, dev_valid, dev_msg, probe_on,
		output peer_valid, peer_msg);
endinterface
`default_nettype wire

/* hdl/lpcn_peer.sv */
`timescale 1ns/1ns
`default_nettype none
module lpcn_peer
	import lpcn_pkg::*;
(
	// link
	lpcn_if.peer             link,
	// own configuration
	input  wire logic        probe_en_i,
	input  wire logic        four_wire_i,
	input  wire logic        regen_i,
	input  wire logic        diag_i,
	input  wire lpcn_psd_t   psd_i,
	input  wire logic [5:0]  base_n_i,
	input  wire logic [5:0]  probe_n_i,
	input  wire logic [2:0]  sub_i_i,
	input  wire logic [3:0]  pbo_i,
	input  wire logic [5:0]  dur_i,
	input  wire logic [2:0]  scr_i,
	input  wire logic [7:0]  wc_oct_i,
	input  wire logic [7:0]  cc_oct_i,
	// decoded far-end request
	output logic             rx_probe_o,
	output logic             rx_four_wire_o,
	output logic             rx_regen_o,
	output logic             rx_diag_o,
	output logic [11:0]      rx_rate_kbps_o,
	output logic             rx_rate_ok_o,
	output logic signed [6:0] rx_wc_db_o,
	output logic signed [6:0] rx_cc_db_o,
	output logic [3:0]       rx_pbo_db_o,
	output logic [11:0]      rx_probe_ms_o,
	output logic [2:0]       rx_scr_o,
	output logic             probing_o,
	output logic             second_o
);
	logic      clk;
	logic      rst;
	logic      own_probe;
	lpcn_msg_t own_msg;

	assign clk = link.clk_i;
	assign rst = link.rst_i;

	// probe capability only while enabled and before the probe has run
	// the answer to the post-probe offer is built while second_o is still low
	assign own_probe = probe_en_i && !second_o && !probing_o;

	// reply message; both margin octets always go out
	always_comb begin
		own_msg            = '0;
		own_msg.probe_mode = own_probe;
		own_msg.four_wire  = four_wire_i;
		own_msg.regen      = regen_i;
		own_msg.diag       = diag_i;
		own_msg.psd        = psd_i;
		own_msg.base_n     = own_probe ? probe_n_i : base_n_i;
		own_msg.sub_i      = sub_i_i;
		own_msg.power_backoff_field        = pbo_i;
		own_msg.dur        = dur_i;
		own_msg.scr        = scr_i;
		own_msg.wc_oct     = wc_oct_i;
		own_msg.cc_oct     = cc_oct_i;
	end

	// answer every message in the next cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			link.peer_valid <= 1'b0;
			link.peer_msg   <= '0;
		end else begin
			link.peer_valid <= link.dev_valid;
			if (link.dev_valid) begin
				link.peer_msg <= own_msg;
			end
		end
	end

	// session tracking: second session follows a run probe
	always_ff @(posedge clk) begin
		if (rst) begin
			probing_o <= 1'b0;
			second_o  <= 1'b0;
		end else begin
			probing_o <= link.probe_on;
			if (probing_o && !link.probe_on) begin
				second_o <= 1'b1;
			end else if (link.dev_valid && link.dev_msg.probe_mode) begin
				second_o <= 1'b0;
			end
		end
	end

	// decode the far end's code points
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_probe_o     <= 1'b0;
			rx_four_wire_o <= 1'b0;
			rx_regen_o     <= 1'b0;
			rx_diag_o      <= 1'b0;
			rx_rate_kbps_o <= 12'h000;
			rx_rate_ok_o   <= 1'b0;
			rx_wc_db_o     <= 7'sh00;
			rx_cc_db_o     <= 7'sh00;
			rx_pbo_db_o    <= 4'h0;
			rx_probe_ms_o  <= 12'h000;
			rx_scr_o       <= 3'h0;
		end else if (link.dev_valid) begin
			rx_probe_o     <= link.dev_msg.probe_mode;
			rx_four_wire_o <= link.dev_msg.four_wire;
			rx_regen_o     <= link.dev_msg.regen;
			rx_diag_o      <= link.dev_msg.diag;
			rx_rate_kbps_o <= rate_kbps(link.dev_msg.psd, link.dev_msg.base_n,
				link.dev_msg.sub_i);
			rx_rate_ok_o   <= rate_ok(link.dev_msg.psd, link.dev_msg.base_n,
				link.dev_msg.sub_i);
			rx_pbo_db_o    <= link.dev_msg.power_backoff_field;
			rx_probe_ms_o  <= dur_ms(link.dev_msg.dur);
			rx_scr_o       <= link.dev_msg.scr;
			// margins in a probe-capability exchange carry no meaning
			if (!link.dev_msg.probe_mode) begin
				rx_wc_db_o <= margin_db(link.dev_msg.wc_oct);
				rx_cc_db_o <= margin_db(link.dev_msg.cc_oct);
			end
		end
	end
endmodule
`default_nettype wire

/* hdl/lpcn_dev.sv */
// Function
// - probe bits use activation level mapping
// - one spectral shaper for every mode
// - rate qualifies when snr less required meets margin
// - both margins given: advertise common rates only
// - handshake first; second handshake after probe
// - probe optional; handshake may go to activation
// - symmetric: 64k base plus 8k sub steps
// - sub field ignored for 2048/2304 asymmetric
// - 768/1536 asymmetric: sub only zero or one
// - base field: probe rate or payload rate
// - backoff field counts whole dB
// - probe duration counts 50 ms units
// - scrambler field selects probe polynomial
// - margin is bits 5..1 minus 10 dB
// - worst-case vs reference, current vs measured noise
// - probe capability sends both margins, receiver ignores
// - flags: four-wire, regenerator, diagnostic train
// - training means activate; probe means run probe
// - software avoids negative current-condition margin
// - advertise only enabled functions
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module lpcn_dev
	import lpcn_pkg::*;
#(
	parameter int UNIT_CYCLES = PROBE_UNIT_CYCLES
) (
	// link
	lpcn_if.dev                   link,
	// wishbone slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [3:0]       wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic [31:0]           wb_dat_o,
	output logic                  wb_ack_o,
	// probe snr estimates
	input  wire logic             snr_valid_i,
	input  wire logic [5:0]       snr_n_i,
	input  wire logic signed [7:0] snr_wc_i,
	input  wire logic signed [7:0] snr_cc_i,
	input  wire logic signed [7:0] snr_req_i,
	// scrambled transmit bits
	input  wire logic             scr_valid_i,
	input  wire logic             scr_bit_i,
	// line side
	output logic signed [2:0]     tx_level_o,
	output logic                  active_o
);
	localparam int UW = $clog2(UNIT_CYCLES + 1);
	localparam logic [UW-1:0] UNIT_LAST = UW'(UNIT_CYCLES - 1);
	logic            clk;
	logic            rst;
	lpcn_ctrl_t      ctrl;
	lpcn_cfg_t       cfg;
	lpcn_stat_t      stat;
	lpcn_rate_t      rate;
	lpcn_state_t     state;
	lpcn_state_t     next_state;
	logic            wr_en;
	logic            go_wr;
	logic            probe_end;
	logic            send;
	lpcn_msg_t       own_msg;
	logic [31:0]     rd_word;
	logic [UW-1:0]   unit_cnt;
	logic [5:0]      seg_cnt;
	logic [5:0]      best_n;
	logic [5:0]      own_n;
	logic [5:0]      agreed_n;
	logic [2:0]      agreed_sub;
	logic            peer_probe;
	logic            peer_four_wire;
	logic            peer_regen;
	logic            peer_diag;
	logic signed [1:0] prev_lvl;
	logic signed [1:0] cur_lvl;
	lpcn_ctrl_t      cur_ctrl;
	assign clk = link.clk_i;
	assign rst = link.rst_i;
	// write takes effect on the edge that sees ack high
	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign go_wr = wr_en && wb_adr_i == ADR_CTRL && wb_sel_i[0] && wb_dat_i[0];
	// a go write must send the fields it writes, not the stale ones
	assign cur_ctrl = go_wr ? lpcn_ctrl_t'(merge(ctrl, wb_dat_i, wb_sel_i)) : ctrl;
	// ack one cycle after the request, dropped the next
	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= rd_word;
		end
	end
	// control and configuration; go is a strobe and never stored
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= '0;
			cfg  <= '0;
		end else if (wr_en) begin
			if (wb_adr_i == ADR_CTRL) begin
				ctrl    <= lpcn_ctrl_t'(merge(ctrl, wb_dat_i, wb_sel_i));
				ctrl.go <= 1'b0;
			end
			if (wb_adr_i == ADR_CFG) begin
				cfg <= lpcn_cfg_t'(merge(cfg, wb_dat_i, wb_sel_i));
			end
		end
	end
	// status views; unmapped and misaligned addresses read zero
	always_comb begin
		stat                = '0;
		stat.phase          = state;
		stat.peer_probe     = peer_probe;
		stat.peer_four_wire = peer_four_wire;
		stat.peer_regen     = peer_regen;
		stat.peer_diag      = peer_diag;
		stat.agreed_n       = agreed_n;
		stat.agreed_sub     = agreed_sub;
		stat.best_n         = best_n;
		case (wb_adr_i)
			ADR_CTRL: rd_word = ctrl;
			ADR_CFG:  rd_word = cfg;
			ADR_STAT: rd_word = stat;
			ADR_RATE: rd_word = rate;
			default:  rd_word = 32'h0000_0000;
		endcase
	end
	// preactivation sequence
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE,
			ST_ACTIVE: begin
				if (go_wr) begin
					next_state = ST_HS1;
				end
			end
			ST_HS1: begin
				if (link.peer_valid) begin
					// probe only when both ends offer it
					next_state = (ctrl.probe_en && link.peer_msg.probe_mode) ?
						ST_PROBE : ST_ACTIVE;
				end
			end
			ST_PROBE: begin
				if (probe_end) begin
					next_state = ST_HS2;
				end
			end
			ST_HS2: begin
				if (link.peer_valid) begin
					next_state = ST_ACTIVE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end
	// probe length: dur units of 50 ms
	assign probe_end = state == ST_PROBE && seg_cnt == cfg.dur;
	always_ff @(posedge clk) begin
		if (rst || state != ST_PROBE) begin
			unit_cnt <= '0;
			seg_cnt  <= 6'h00;
		end else if (unit_cnt == UNIT_LAST) begin
			unit_cnt <= '0;
			seg_cnt  <= seg_cnt + 6'h01;
		end else begin
			unit_cnt <= unit_cnt + UW'(1);
		end
	end
	// highest rate passing both noise cases; zero means none
	always_ff @(posedge clk) begin
		if (rst || go_wr) begin
			best_n <= 6'h00;
		end else if (state == ST_PROBE && snr_valid_i && snr_n_i > best_n &&
			rate_ok(ctrl.psd, snr_n_i, SUB_I_ZERO) &&
			qualifies(snr_wc_i, snr_req_i, cfg.wc_oct) &&
			qualifies(snr_cc_i, snr_req_i, cfg.cc_oct)) begin
			best_n <= snr_n_i;
		end
	end
	// outgoing message; first session offers probe, second reports results
	assign send  = (go_wr && (state == ST_IDLE || state == ST_ACTIVE)) || probe_end;
	assign own_n = probe_end ? best_n : cur_ctrl.base_n;
	always_comb begin
		own_msg            = '0;
		own_msg.probe_mode = cur_ctrl.probe_en && !probe_end;
		own_msg.four_wire  = cur_ctrl.four_wire;
		own_msg.regen      = cur_ctrl.regen;
		own_msg.diag       = cur_ctrl.diag;
		own_msg.psd        = cur_ctrl.psd;
		own_msg.base_n     = own_msg.probe_mode ? cur_ctrl.probe_n : own_n;
		own_msg.sub_i      = cur_ctrl.sub_i;
		own_msg.power_backoff_field        = cfg.power_backoff_field;
		own_msg.dur        = cfg.dur;
		own_msg.scr        = cfg.scr;
		own_msg.wc_oct     = cfg.wc_oct;
		own_msg.cc_oct     = cfg.cc_oct;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			link.dev_valid <= 1'b0;
			link.dev_msg   <= '0;
			link.probe_on  <= 1'b0;
		end else begin
			link.dev_valid <= send;
			link.probe_on  <= next_state == ST_PROBE;
			if (send) begin
				link.dev_msg <= own_msg;
			end
		end
	end
	// peer answer: flags always, agreed rate when it selects training
	always_ff @(posedge clk) begin
		if (rst) begin
			peer_probe     <= 1'b0;
			peer_four_wire <= 1'b0;
			peer_regen     <= 1'b0;
			peer_diag      <= 1'b0;
			agreed_n       <= 6'h00;
			agreed_sub     <= 3'h0;
			rate           <= '0;
		end else if (link.peer_valid && (state == ST_HS1 || state == ST_HS2)) begin
			peer_probe     <= link.peer_msg.probe_mode;
			peer_four_wire <= link.peer_msg.four_wire;
			peer_regen     <= link.peer_msg.regen;
			peer_diag      <= link.peer_msg.diag;
			if (next_state == ST_ACTIVE) begin
				agreed_n   <= (link.dev_msg.base_n < link.peer_msg.base_n) ?
					link.dev_msg.base_n : link.peer_msg.base_n;
				agreed_sub <= (link.dev_msg.sub_i < link.peer_msg.sub_i) ?
					link.dev_msg.sub_i : link.peer_msg.sub_i;
				rate.kbps  <= rate_kbps(ctrl.psd, link.dev_msg.base_n,
					link.dev_msg.sub_i);
				rate.ok    <= rate_ok(ctrl.psd, link.dev_msg.base_n, link.dev_msg.sub_i) &&
					link.peer_msg.psd == ctrl.psd;
			end
		end
	end
	// probe and activation share level mapping and shaper
	assign cur_lvl = map_level(scr_bit_i);
	always_ff @(posedge clk) begin
		if (rst) begin
			prev_lvl   <= 2'sh0;
			tx_level_o <= 3'sh0;
			active_o   <= 1'b0;
		end else begin
			active_o <= state == ST_ACTIVE;
			if ((state == ST_PROBE || state == ST_ACTIVE) && scr_valid_i) begin
				prev_lvl   <= cur_lvl;
				tx_level_o <= shape(cur_lvl, prev_lvl);
			end else if (state != ST_PROBE && state != ST_ACTIVE) begin
				prev_lvl   <= 2'sh0;
				tx_level_o <= 3'sh0;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/lpcn_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module lpcn_checker
	import lpcn_pkg::*;
#(
	parameter int UNIT_CYCLES = 8
) (
	// clock and reset
	input wire logic      clk_i,
	input wire logic      rst_i,
	// link signals
	input wire logic      dev_valid,
	input wire lpcn_msg_t dev_msg,
	input wire logic      peer_valid,
	input wire lpcn_msg_t peer_msg,
	input wire logic      probe_on
);
	int unsigned cnt;
	int unsigned lim;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// cycles spent in probe so far
	always_ff @(posedge clk_i) begin
		cnt <= (probe_on && !rst_i) ? cnt + 1 : 0;
	end

	// expected probe length, latched from the probe-mode offer; the exit cycle counts too
	always_ff @(posedge clk_i) begin
		if (dev_valid && dev_msg.probe_mode) begin
			lim <= dev_msg.dur * UNIT_CYCLES + 1;
		end
	end

	// one offer answered by the peer
	sequence s_exchange;
		dev_valid ##1 peer_valid;
	endsequence

	// both sides offered a probe session
	sequence s_both_probe;
		dev_msg.probe_mode && peer_msg.probe_mode;
	endsequence

	a_answer_next: assert property (dev_valid |=> peer_valid)
		else $error("offer not answered in the next cycle");
	a_answer_caused: assert property (peer_valid |-> $past(dev_valid))
		else $error("answer without an offer");
	a_offer_paced: assert property (dev_valid |=> !dev_valid)
		else $error("new offer before the answer");
	a_probe_entry: assert property (s_exchange ##0 s_both_probe |=> probe_on)
		else $error("probe not entered after probe exchange");
	a_probe_skipped: assert property (s_exchange ##0 !s_both_probe |=> !probe_on)
		else $error("probe entered without both offers");
	a_second_hs: assert property ($fell(probe_on) |-> dev_valid && !dev_msg.probe_mode)
		else $error("no training offer at probe end");
	a_probe_len: assert property ($fell(probe_on) |-> cnt == lim)
		else $error("probe length differs from duration field");
	a_dev_stands: assert property (!dev_valid |-> $stable(dev_msg))
		else $error("device message changed without valid");
	a_peer_stands: assert property (!peer_valid |-> $stable(peer_msg))
		else $error("peer message changed without valid");
endmodule
`default_nettype wire

/* testbench/tb_line_probe_capability_negotiation.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_line_probe_capability_negotiation
	import lpcn_pkg::*;
;
	localparam int UNIT = 8;
	logic              clk_i = 1'b0;
	logic              rst_i = 1'b1;
	logic              cyc = 1'b0;
	logic              stb = 1'b0;
	logic              we = 1'b0;
	logic [3:0]        adr = 4'h0;
	logic [3:0]        sel = 4'h0;
	logic [31:0]       wdat = 32'h0;
	logic [31:0]       rdat;
	logic              ack;
	logic              snr_v = 1'b0;
	logic [5:0]        snr_n = 6'h00;
	logic signed [7:0] snr_wc = 8'sh00;
	logic signed [7:0] snr_cc = 8'sh00;
	logic signed [7:0] snr_req = 8'sh00;
	logic              scr_v = 1'b0;
	logic              scr_b = 1'b0;
	logic signed [2:0] tx_level;
	logic              active;
	// peer capabilities: no probe, regenerator, symmetric n=20 i=1
	lpcn_msg_t         pcfg = {4'h2, PSD_SYM, 6'h14, 3'h1, 4'h2, 6'h02, 3'h3, 8'h1f, 8'h15};
	logic              rx_probe, rx_four, rx_regen, rx_diag, rx_ok, probing, second;
	logic [11:0]       rx_kbps, rx_ms;
	logic signed [6:0] rx_wc, rx_cc;
	logic [3:0]        rx_pbo;
	logic [2:0]        rx_scr;
	logic [31:0]       rd;
	logic [31:0]       v;
	int                errors = 0;
	int                total_checks = 0;

	// free-running bench clock
	always #25 clk_i = ~clk_i;

	lpcn_if lpcn_if_inst (.clk_i(clk_i), .rst_i(rst_i));
	lpcn_dev #(.UNIT_CYCLES(UNIT)) lpcn_dev_inst (.link(lpcn_if_inst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .snr_valid_i(snr_v), .snr_n_i(snr_n),
		.snr_wc_i(snr_wc), .snr_cc_i(snr_cc), .snr_req_i(snr_req), .scr_valid_i(scr_v),
		.scr_bit_i(scr_b), .tx_level_o(tx_level), .active_o(active));
	lpcn_peer lpcn_peer_inst (.link(lpcn_if_inst), .probe_en_i(pcfg.probe_mode),
		.four_wire_i(pcfg.four_wire), .regen_i(pcfg.regen), .diag_i(pcfg.diag),
		.psd_i(pcfg.psd), .base_n_i(pcfg.base_n), .probe_n_i(pcfg.base_n),
		.sub_i_i(pcfg.sub_i), .pbo_i(pcfg.power_backoff_field), .dur_i(pcfg.dur), .scr_i(pcfg.scr),
		.wc_oct_i(pcfg.wc_oct), .cc_oct_i(pcfg.cc_oct), .rx_probe_o(rx_probe),
		.rx_four_wire_o(rx_four), .rx_regen_o(rx_regen), .rx_diag_o(rx_diag),
		.rx_rate_kbps_o(rx_kbps), .rx_rate_ok_o(rx_ok), .rx_wc_db_o(rx_wc),
		.rx_cc_db_o(rx_cc), .rx_pbo_db_o(rx_pbo), .rx_probe_ms_o(rx_ms), .rx_scr_o(rx_scr),
		.probing_o(probing), .second_o(second));
	lpcn_checker #(.UNIT_CYCLES(UNIT)) lpcn_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
		.dev_valid(lpcn_if_inst.dev_valid), .dev_msg(lpcn_if_inst.dev_msg),
		.peer_valid(lpcn_if_inst.peer_valid), .peer_msg(lpcn_if_inst.peer_msg),
		.probe_on(lpcn_if_inst.probe_on));

	// compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one classic wishbone cycle; read data lands in rd
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		@(posedge clk_i);
		while (ack !== 1'b1) begin
			@(posedge clk_i);
		end
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	// bounded wait for the probe level
	task automatic await(input logic lvl, input int lim);
		int n;
		n = 0;
		while (lpcn_if_inst.probe_on !== lvl && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		if (n == lim) errors++;
	endtask

	// handshake without probe takes a few cycles after go
	task automatic start(input logic [31:0] c);
		wb(1'b1, ADR_CTRL, c);
		repeat (5) @(posedge clk_i);
	endtask

	// offer one rate code point and look at both decodes
	task automatic rate(input lpcn_psd_t p, input logic [5:0] n, input logic [2:0] i,
		input logic [11:0] k, input logic ok);
		pcfg.psd <= p; // peer shares the spectrum under test
		start({9'h000, 6'h0a, i, n, p, 5'h0d});
		check("rx kbps", rx_kbps, k);
		check("rx ok", rx_ok, ok);
		wb(1'b0, ADR_RATE, 32'h0);
		check("rate reg", rd, {19'h0, ok, k});
	endtask

	// one snr estimate per cycle; valid stays up between calls
	task automatic snr(input logic [5:0] n, input logic signed [7:0] w, input logic signed [7:0] c);
		snr_v <= 1'b1;
		snr_n <= n;
		snr_wc <= w;
		snr_cc <= c;
		@(posedge clk_i);
	endtask

	// verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// hang guard, far above the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge clk_i);
		errors++;
		wrap_up();
	end

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// reset values, misaligned write refused
		check("idle level", tx_level, 32'h0);
		for (int a = 0; a < 16; a += 2) begin
			wb(1'b0, 4'(a), 32'h0);
			check("reset read", rd, 32'h0);
		end
		wb(1'b1, 4'h6, 32'hffffffff);
		wb(1'b0, ADR_CFG, 32'h0);
		check("cfg kept", rd, 32'h0);
		$display("test reset done");
		// straight handshake, no probe
		v = {3'h0, 8'h1f, 8'h09, 3'h5, 6'h03, 4'h7};
		wb(1'b1, ADR_CFG, v);
		wb(1'b0, ADR_CFG, 32'h0);
		check("cfg", rd, v);
		v = {9'h000, 6'h0a, 3'h1, 6'h24, PSD_SYM, 5'h0d};
		start(v);
		check("active", active, 32'h1);
		check("rx probe", rx_probe, 32'h0);
		check("rx four", rx_four, 32'h1);
		check("rx diag", rx_diag, 32'h1);
		check("rx regen", rx_regen, 32'h0);
		check("rx pbo", rx_pbo, 32'h7);
		check("rx ms", rx_ms, 32'h96);
		check("rx scr", rx_scr, 32'h5);
		check("rx wc", rx_wc, 32'hfffffffa);
		check("rx cc", rx_cc, 32'h5);
		wb(1'b0, ADR_CTRL, 32'h0);
		check("ctrl", rd, v & 32'hfffffffe);
		wb(1'b0, ADR_STAT, 32'h0);
		check("stat", rd, {16'h0, 3'h1, 6'h14, 4'h4, ST_ACTIVE});
		$display("test handshake done");
		// rate code points of every spectrum
		rate(PSD_SYM, 6'h24, 3'h1, 12'h908, 1'b1);
		rate(PSD_SYM, 6'h24, 3'h2, 12'h910, 1'b0);
		rate(PSD_SYM, 6'h03, 3'h7, 12'h0f8, 1'b1);
		rate(PSD_SYM, 6'h02, 3'h0, 12'h080, 1'b0);
		rate(PSD_ASYM768, 6'h0c, 3'h1, 12'h308, 1'b1);
		rate(PSD_ASYM1536, 6'h18, 3'h2, 12'h600, 1'b0);
		rate(PSD_ASYM2048, 6'h20, 3'h5, 12'h800, 1'b1);
		rate(PSD_ASYM2304, 6'h24, 3'h7, 12'h900, 1'b1);
		$display("test rates done");
		// probe run: 5 dB worst case, 0 dB current, two units long
		pcfg.probe_mode <= 1'b1;
		pcfg.psd <= PSD_SYM;
		wb(1'b1, ADR_CFG, {3'h0, 8'h15, 8'h1f, 3'h1, 6'h02, 4'h3});
		wb(1'b1, ADR_CTRL, {9'h000, 6'h0a, 3'h0, 6'h24, PSD_SYM, 5'h0f});
		await(1'b1, 20);
		check("rx probe", rx_probe, 32'h1);
		check("rx wc held", rx_wc, 32'hfffffffa);
		scr_v <= 1'b1;
		scr_b <= 1'b1;
		snr_req <= 8'sh0a;
		snr(6'h0a, 8'sh10, 8'sh0c);
		snr(6'h14, 8'sh0e, 8'sh14);
		snr(6'h0f, 8'sh0f, 8'sh09);
		snr(6'h0c, 8'sh0f, 8'sh0a);
		snr(6'h08, 8'sh1e, 8'sh1e);
		snr(6'h1e, 8'shf0, 8'shf0);
		snr_v <= 1'b0;
		scr_v <= 1'b0;
		repeat (2) @(posedge clk_i);
		check("probe level", tx_level, 32'h2);
		check("probing", probing, 32'h1);
		await(1'b0, 40);
		repeat (5) @(posedge clk_i);
		check("second", second, 32'h1);
		check("rx kbps", rx_kbps, 32'h300);
		check("rx wc", rx_wc, 32'h5);
		check("rx cc", rx_cc, 32'h0);
		check("active", active, 32'h1);
		wb(1'b0, ADR_STAT, 32'h0);
		check("best n", rd[21:16], 32'h0c);
		check("peer probe", rd[3], 32'h0);
		// data mode uses the same mapper and shaper
		scr_v <= 1'b1;
		scr_b <= 1'b0;
		repeat (3) @(posedge clk_i);
		scr_v <= 1'b0;
		@(posedge clk_i);
		check("active level", tx_level, 32'hfffffffe);
		$display("test probe done");
		wrap_up();
	end
endmodule
`default_nettype wire
